//--- src/drt_timer.sv
// dual reload timer top: io registers, time base, flags, pin action
`timescale 1ns/100ps
module drt_timer (
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // processor io access
    input  wire logic [7:0] i_io_addr,
    input  wire logic       i_io_rd,
    input  wire logic       i_io_wr,
    input  wire logic [7:0] i_io_wdata,
    output logic [7:0]      o_io_rdata,
    output logic            o_io_ack,
    // shared address and timer pin
    input  wire logic       i_addr_bit18,
    input  wire logic       i_vector_low_config_b3,
    output logic            o_shared_addr_timer_pin,
    // interrupt requests
    output logic            o_irq_chan0,
    output logic            o_irq_chan1
);
    import drt_pkg::*;

    typedef struct packed {
        logic [4:0] prescale;
        logic       tick;
        logic       flag1;
        logic       flag0;
        logic       ie1;
        logic       ie0;
        logic [1:0] act;
        logic       en1;
        logic       en0;
        logic       armed1;
        logic       armed0;
        logic       tout;
        logic       pin;
        logic       irq0;
        logic       irq1;
        logic [7:0] rdata;
        logic       ack;
    } drt_top_st_t;

    drt_top_st_t st;
    drt_top_st_t next_st;

    drt_ch_if ch0 ();
    drt_ch_if ch1 ();

    logic [7:0] ctrl_view;
    logic       rd_cnt0;
    logic       rd_cnt1;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    drt_chan u_chan0 (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .ch     (ch0)
    );

    drt_chan u_chan1 (
        .i_mclk (i_mclk),
        .i_rstn (i_rstn),
        .ch     (ch1)
    );

    assign ch0.tick      = st.tick;
    assign ch1.tick      = st.tick;
    assign ch0.run       = st.en0;
    assign ch1.run       = st.en1;
    assign ch0.wdata     = i_io_wdata;
    assign ch1.wdata     = i_io_wdata;
    assign ch0.wr_cnt_lo = i_io_wr && !st.en0
                           && i_io_addr == ADDR_CH0_CNT_LO;     // RULE13
    assign ch0.wr_cnt_hi = i_io_wr && !st.en0
                           && i_io_addr == ADDR_CH0_CNT_HI;     // RULE13
    assign ch0.wr_rld_lo = i_io_wr && i_io_addr == ADDR_CH0_RLD_LO; // RULE14
    assign ch0.wr_rld_hi = i_io_wr && i_io_addr == ADDR_CH0_RLD_HI; // RULE14
    assign ch1.wr_cnt_lo = i_io_wr && !st.en1
                           && i_io_addr == ADDR_CH1_CNT_LO;
    assign ch1.wr_cnt_hi = i_io_wr && !st.en1
                           && i_io_addr == ADDR_CH1_CNT_HI;
    assign ch1.wr_rld_lo = i_io_wr && i_io_addr == ADDR_CH1_RLD_LO;
    assign ch1.wr_rld_hi = i_io_wr && i_io_addr == ADDR_CH1_RLD_HI;

    assign ctrl_view = {st.flag1, st.flag0, st.ie1, st.ie0,
                        st.act, st.en1, st.en0};
    assign rd_cnt0   = i_io_rd && (i_io_addr == ADDR_CH0_CNT_LO
                                   || i_io_addr == ADDR_CH0_CNT_HI);
    assign rd_cnt1   = i_io_rd && (i_io_addr == ADDR_CH1_CNT_LO
                                   || i_io_addr == ADDR_CH1_CNT_HI);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // divide by twenty time base
        next_st.tick = (st.prescale == TICK_LAST);              // RULE2
        next_st.prescale = next_st.tick ? 5'h00
                                        : st.prescale + 5'h01;  // RULE2
        // read side effects: arm, then clear
        if (i_io_rd && i_io_addr == ADDR_CTRL) begin
            next_st.armed1 = st.flag1;                          // RULE5
            next_st.armed0 = st.flag0;                          // RULE5
        end
        if (rd_cnt1 && st.armed1) begin
            next_st.flag1  = 1'b0;                              // RULE5
            next_st.armed1 = 1'b0;
        end
        if (rd_cnt0 && st.armed0) begin
            next_st.flag0  = 1'b0;                              // RULE5
            next_st.armed0 = 1'b0;
        end
        // zero events win over clears
        if (ch1.zero) begin
            next_st.flag1 = 1'b1;                               // RULE3
        end
        if (ch0.zero) begin
            next_st.flag0 = 1'b1;                               // RULE4
        end
        // control write, flags read only
        if (i_io_wr && i_io_addr == ADDR_CTRL) begin
            next_st.ie1 = i_io_wdata[CTRL_IE1_BIT];
            next_st.ie0 = i_io_wdata[CTRL_IE0_BIT];
            next_st.act = i_io_wdata[CTRL_ACT_HI:CTRL_ACT_LO];
            next_st.en1 = i_io_wdata[CTRL_EN1_BIT];             // RULE11
            next_st.en0 = i_io_wdata[CTRL_EN0_BIT];             // RULE11
        end
        // pin action at channel 1 zero
        if (ch1.zero) begin
            unique case (st.act)                                // RULE8
                ACT_NONE:   next_st.tout = st.tout;
                ACT_TOGGLE: next_st.tout = !st.tout;
                ACT_LOW:    next_st.tout = 1'b0;
                ACT_HIGH:   next_st.tout = 1'b1;
            endcase
        end
        next_st.pin = i_vector_low_config_b3 ? st.tout
                                             : i_addr_bit18;    // RULE9
        next_st.irq0 = st.flag0 && st.ie0;                      // RULE4
        next_st.irq1 = st.flag1 && st.ie1;                      // RULE6
        // io read data
        next_st.ack = i_io_rd || i_io_wr;
        if (i_io_rd) begin
            unique case (i_io_addr)
                ADDR_CH0_CNT_LO: next_st.rdata = ch0.count[7:0];
                ADDR_CH0_CNT_HI: next_st.rdata = ch0.count[15:8];
                ADDR_CH0_RLD_LO: next_st.rdata = ch0.reload[7:0];
                ADDR_CH0_RLD_HI: next_st.rdata = ch0.reload[15:8];
                ADDR_CTRL:       next_st.rdata = ctrl_view;     // RULE15
                ADDR_CH1_CNT_LO: next_st.rdata = ch1.count[7:0];
                ADDR_CH1_CNT_HI: next_st.rdata = ch1.count[15:8];
                ADDR_CH1_RLD_LO: next_st.rdata = ch1.reload[7:0];
                ADDR_CH1_RLD_HI: next_st.rdata = ch1.reload[15:8];
                default:         next_st.rdata = RDATA_UNMAP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            st        <= '0;                                    // RULE7
            st.act    <= CTRL_RESET[CTRL_ACT_HI:CTRL_ACT_LO];   // RULE10
            st.tout   <= PIN_RESET;
            st.rdata  <= RDATA_UNMAP;
        end else begin
            st <= next_st;
        end
    end

    assign o_io_rdata              = st.rdata;
    assign o_io_ack                = st.ack;
    assign o_shared_addr_timer_pin = st.pin;
    assign o_irq_chan0             = st.irq0;
    assign o_irq_chan1             = st.irq1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_tick_period;
        @(posedge i_mclk) disable iff (!i_rstn)
        st.tick |-> ##20 st.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) // RULE2
        else $error("time base period is not twenty clocks");

    property p_flag1_set;
        @(posedge i_mclk) disable iff (!i_rstn)
        ch1.zero |=> st.flag1;
    endproperty
    a_flag1_set: assert property (p_flag1_set) // RULE3
        else $error("channel 1 flag missed a zero");

    property p_flag0_set;
        @(posedge i_mclk) disable iff (!i_rstn)
        ch0.zero |=> st.flag0;
    endproperty
    a_flag0_set: assert property (p_flag0_set) // RULE4
        else $error("channel 0 flag missed a zero");

    property p_flag_clear;
        @(posedge i_mclk) disable iff (!i_rstn)
        $fell(st.flag1) |-> $past(st.armed1) && $past(rd_cnt1);
    endproperty
    a_flag_clear: assert property (p_flag_clear) // RULE5
        else $error("channel 1 flag cleared without read sequence");

    property p_irq0;
        @(posedge i_mclk) disable iff (!i_rstn)
        ##1 (o_irq_chan0 == $past(st.flag0 && st.ie0));
    endproperty
    a_irq0: assert property (p_irq0) // RULE4
        else $error("channel 0 request does not follow flag and enable");

    property p_irq1;
        @(posedge i_mclk) disable iff (!i_rstn)
        ##1 (o_irq_chan1 == $past(st.flag1 && st.ie1));
    endproperty
    a_irq1: assert property (p_irq1) // RULE6
        else $error("channel 1 request wrong");

    property p_reset_clear;
        @(posedge i_mclk)
        !i_rstn |=> (ctrl_view == CTRL_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) // RULE7
        else $error("control not cleared by reset");

    property p_toggle;
        @(posedge i_mclk) disable iff (!i_rstn)
        (ch1.zero && st.act == ACT_TOGGLE) |=> (st.tout != $past(st.tout));
    endproperty
    a_toggle: assert property (p_toggle) // RULE8
        else $error("pin did not toggle at channel 1 zero");

    property p_pin_sel;
        @(posedge i_mclk) disable iff (!i_rstn)
        ##1 (o_shared_addr_timer_pin == ($past(i_vector_low_config_b3)
             ? $past(st.tout) : $past(i_addr_bit18)));
    endproperty
    a_pin_sel: assert property (p_pin_sel) // RULE9
        else $error("shared pin source wrong");

    c_zero0: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        ch0.zero);
    c_clear1: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        $fell(st.flag1));
    c_toggle: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        ch1.zero && st.act == ACT_TOGGLE && i_vector_low_config_b3);

endmodule

//--- src/drt_pkg.sv
// constants for the dual reload timer
// What this block does
// RULE1 - two channels, each a 16-bit down-counter with a 16-bit reload
// RULE2 - counters step on a time base of system clock divided by twenty
// RULE3 - channel 1 zero flag, control bit 7, sets when counter hits zero
// RULE4 - channel 0 zero flag, control bit 6; interrupt only if its enable set
// RULE5 - flag clears after control read, then that channel's count byte read
// RULE6 - channel 1 interrupt request when its flag and enable bit 5 are set
// RULE7 - reset clears both zero flags and both interrupt enables
// RULE8 - bits 3:2 act on pin at channel 1 zero: none, toggle, low, high
// RULE9 - pin carries timer output only while vector low config bit 3 is one
// RULE10 - reset clears the pin action field to 00
// RULE11 - bits 1 and 0 enable counting, cleared at reset, counter holds
// RULE12 - stopped channel counter bytes are freely read and written
// RULE13 - channel 0 counter low byte at 0ch, high byte at 0dh
// RULE14 - channel 0 reload low byte at 0eh, high byte at 0fh
// RULE15 - shared control and status register at 10h
// RULE16 - enabled counter at zero reloads on next tick and keeps counting
package drt_pkg;

    // ------------------------------------------------------------
    // io addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CH0_CNT_LO = 8'h0c;
    localparam logic [7:0] ADDR_CH0_CNT_HI = 8'h0d;
    localparam logic [7:0] ADDR_CH0_RLD_LO = 8'h0e;
    localparam logic [7:0] ADDR_CH0_RLD_HI = 8'h0f;
    localparam logic [7:0] ADDR_CTRL       = 8'h10;
    localparam logic [7:0] ADDR_CH1_CNT_LO = 8'h14;
    localparam logic [7:0] ADDR_CH1_CNT_HI = 8'h15;
    localparam logic [7:0] ADDR_CH1_RLD_LO = 8'h16;
    localparam logic [7:0] ADDR_CH1_RLD_HI = 8'h17;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_FLAG1_BIT = 7;
    localparam int CTRL_FLAG0_BIT = 6;
    localparam int CTRL_IE1_BIT   = 5;
    localparam int CTRL_IE0_BIT   = 4;
    localparam int CTRL_ACT_HI    = 3;
    localparam int CTRL_ACT_LO    = 2;
    localparam int CTRL_EN1_BIT   = 1;
    localparam int CTRL_EN0_BIT   = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // pin action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW    = 2'h2;
    localparam logic [1:0] ACT_HIGH   = 2'h3;

    // ------------------------------------------------------------
    // widths, timing, reset values
    // ------------------------------------------------------------
    localparam int          CNT_W       = 16;
    localparam int          TICK_DIV    = 20;
    localparam logic [4:0]  TICK_LAST   = 5'(TICK_DIV - 1);
    localparam logic [15:0] CNT_RESET   = 16'hffff;
    localparam logic [15:0] RLD_RESET   = 16'hffff;
    localparam logic        PIN_RESET   = 1'b0;
    localparam logic [7:0]  RDATA_UNMAP = 8'h00;

endpackage

//--- src/drt_ch_if.sv
// carrier between timer control and one counter channel
`timescale 1ns/100ps
interface drt_ch_if;
    logic        tick;
    logic        run;
    logic        wr_cnt_lo;
    logic        wr_cnt_hi;
    logic        wr_rld_lo;
    logic        wr_rld_hi;
    logic [7:0]  wdata;
    logic [15:0] count;
    logic [15:0] reload;
    logic        zero;

    modport ctrl (output tick, run, wr_cnt_lo, wr_cnt_hi, wr_rld_lo,
                  wr_rld_hi, wdata, input count, reload, zero);
    modport chan (input tick, run, wr_cnt_lo, wr_cnt_hi, wr_rld_lo,
                  wr_rld_hi, wdata, output count, reload, zero);
endinterface

//--- src/drt_chan.sv
// one reload timer channel: down-counter and reload register
`timescale 1ns/100ps
module drt_chan (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    // control side
    drt_ch_if.chan    ch
);
    import drt_pkg::*;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic        zero;
    } drt_chan_st_t;

    drt_chan_st_t st;
    drt_chan_st_t next_st;

    // ------------------------------------------------------------
    // counting and byte writes
    // ------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.zero = 1'b0;
        if (ch.tick && ch.run) begin                            // RULE11
            if (st.count == 16'h0000) begin
                next_st.count = st.reload;                      // RULE16
            end else begin
                next_st.count = st.count - 16'h0001;            // RULE1
                next_st.zero  = (st.count == 16'h0001);
            end
        end
        if (ch.wr_cnt_lo) begin
            next_st.count[7:0] = ch.wdata;                      // RULE12
        end
        if (ch.wr_cnt_hi) begin
            next_st.count[15:8] = ch.wdata;                     // RULE12
        end
        if (ch.wr_rld_lo) begin
            next_st.reload[7:0] = ch.wdata;
        end
        if (ch.wr_rld_hi) begin
            next_st.reload[15:8] = ch.wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            st <= '{count: CNT_RESET, reload: RLD_RESET, zero: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign ch.count  = st.count;
    assign ch.reload = st.reload;
    assign ch.zero   = st.zero;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_hold_stopped;
        @(posedge i_mclk) disable iff (!i_rstn)
        (!ch.run && !ch.wr_cnt_lo && !ch.wr_cnt_hi) |=> $stable(st.count);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) // RULE11
        else $error("stopped counter changed");

    property p_reload_at_zero;
        @(posedge i_mclk) disable iff (!i_rstn)
        (ch.tick && ch.run && st.count == 16'h0000 && !ch.wr_cnt_lo
         && !ch.wr_cnt_hi) |=> (st.count == $past(st.reload));
    endproperty
    a_reload_at_zero: assert property (p_reload_at_zero) // RULE16
        else $error("counter did not reload at zero");

    property p_zero_pulse;
        @(posedge i_mclk) disable iff (!i_rstn)
        st.zero |-> (st.count == 16'h0000 || $past(ch.wr_cnt_lo)
                     || $past(ch.wr_cnt_hi));
    endproperty
    a_zero_pulse: assert property (p_zero_pulse) // RULE1
        else $error("zero pulse without zero count");

endmodule

//--- tb/dual_reload_timer_test.sv
// self-checking bench for the dual reload timer
`timescale 1ns/100ps
`define chk(name, exp, got) begin num_checks++; \
    if ((got) !== (exp)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); \
    end end
module dual_reload_timer_test;
    import drt_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       i_mclk;
    logic       i_rstn;
    logic [7:0] io_addr;
    logic       io_rd;
    logic       io_wr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic       io_ack;
    logic       addr_bit18;
    logic       pin_sel;
    logic       pin;
    logic       irq0;
    logic       irq1;
    int         err_total;
    int         num_checks;
    int         cyc = 0;

    drt_timer drt_timer_i (
        .i_mclk                 (i_mclk),
        .i_rstn                 (i_rstn),
        .i_io_addr              (io_addr),
        .i_io_rd                (io_rd),
        .i_io_wr                (io_wr),
        .i_io_wdata             (io_wdata),
        .o_io_rdata             (io_rdata),
        .o_io_ack               (io_ack),
        .i_addr_bit18           (addr_bit18),
        .i_vector_low_config_b3 (pin_sel),
        .o_shared_addr_timer_pin(pin),
        .o_irq_chan0            (irq0),
        .o_irq_chan1            (irq1)
    );

    // ------------------------------------------------------------
    // clock, cycle count, watchdog
    // ------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) cyc <= cyc + 1;

    initial begin
        #(30000 * 4);
        err_total++;
        summarize();
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic summarize();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic io_acc(input logic w, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge i_mclk);
        io_addr  = a;
        io_wdata = d;
        io_rd    = !w;
        io_wr    = w;
        @(negedge i_mclk);
        io_rd = 1'b0;
        io_wr = 1'b0;
        n = 0;
        while (io_ack !== 1'b1 && n < 4) begin
            @(negedge i_mclk);
            n++;
        end
        `chk("io_ack", 1'b1, io_ack)
        q = io_rdata;
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        io_acc(1'b1, a, d, q);
    endtask

    task automatic rd8(input logic [7:0] a, output logic [7:0] q);
        io_acc(1'b0, a, 8'h00, q);
    endtask

    task automatic wait_pin(output int t);
        logic p;
        int   n;
        p = pin;
        n = 0;
        while (pin === p && n < 400) begin
            @(negedge i_mclk);
            n++;
        end
        t = cyc;
    endtask

    function automatic logic exp_pin(logic [1:0] c, logic prev);
        case (c)
            ACT_NONE:   return prev;
            ACT_TOGGLE: return ~prev;
            ACT_LOW:    return 1'b0;
            default:    return 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin : main
        logic [7:0] addrs [8];
        logic [7:0] vals [8];
        logic [7:0] q;
        logic [7:0] v;
        logic [1:0] codes [6];
        logic       prev;
        int         t1;
        int         t2;
        int         n;
        addrs = '{ADDR_CH0_CNT_LO, ADDR_CH0_CNT_HI, ADDR_CH0_RLD_LO,
                  ADDR_CH0_RLD_HI, ADDR_CH1_CNT_LO, ADDR_CH1_CNT_HI,
                  ADDR_CH1_RLD_LO, ADDR_CH1_RLD_HI};
        codes = '{ACT_HIGH, ACT_NONE, ACT_LOW, ACT_NONE, ACT_TOGGLE,
                  ACT_TOGGLE};
        err_total  = 0;
        num_checks = 0;
        i_rstn     = 1'b0;
        io_addr    = 8'h00;
        io_rd      = 1'b0;
        io_wr      = 1'b0;
        io_wdata   = 8'h00;
        addr_bit18 = 1'b0;
        pin_sel    = 1'b0;
        void'($urandom(32'h6823));
        repeat (4) @(negedge i_mclk);
        `chk("irq_reset", 2'b00, {irq1, irq0})
        i_rstn = 1'b1;
        // reset values
        rd8(ADDR_CTRL, q);
        `chk("ctrl_reset", CTRL_RESET, q)
        foreach (addrs[i]) begin
            rd8(addrs[i], q);
            `chk("count_reload_reset", 8'hff, q)
        end
        pin_sel = 1'b1;
        repeat (2) @(negedge i_mclk);
        `chk("pin_reset", PIN_RESET, pin)
        // random byte access while stopped
        foreach (addrs[i]) begin
            vals[i] = 8'($urandom);
            wr8(addrs[i], vals[i]);
        end
        repeat (60) @(negedge i_mclk);
        foreach (addrs[i]) begin
            rd8(addrs[i], q);
            `chk("stopped_byte", vals[i], q)
        end
        v = 8'h20 + 8'($urandom % 64);
        wr8(v, 8'($urandom));
        rd8(v, q);
        `chk("unmapped", RDATA_UNMAP, q)
        v = 8'($urandom) & 8'h3c;
        wr8(ADDR_CTRL, v | 8'hc0);
        rd8(ADDR_CTRL, q);
        `chk("ctrl_rw", v, q)
        `chk("irq_no_flag", 2'b00, {irq1, irq0})
        wr8(ADDR_CTRL, 8'h00);
        // count write refused while running
        wr8(ADDR_CH0_CNT_LO, 8'h00);
        wr8(ADDR_CH0_CNT_HI, 8'h10);
        wr8(ADDR_CTRL, 8'h01);
        wr8(ADDR_CH0_CNT_LO, 8'h55);
        wr8(ADDR_CTRL, 8'h00);
        rd8(ADDR_CH0_CNT_LO, q);
        `chk("run_write", 1'b1, (q === 8'h00 || q === 8'hff))
        // channel 0 flag, enable and clear order
        wr8(ADDR_CH0_CNT_LO, 8'h02);
        wr8(ADDR_CH0_CNT_HI, 8'h00);
        wr8(ADDR_CTRL, 8'h01);
        repeat (100) @(negedge i_mclk);
        wr8(ADDR_CTRL, 8'h00);
        `chk("irq0_masked", 1'b0, irq0)
        rd8(ADDR_CH0_CNT_LO, q);
        wr8(ADDR_CTRL, 8'h10);
        repeat (3) @(negedge i_mclk);
        `chk("irq0_on", 1'b1, irq0)
        rd8(ADDR_CTRL, q);
        `chk("flag0", 1'b1, q[CTRL_FLAG0_BIT])
        rd8(ADDR_CH1_CNT_LO, q);
        repeat (3) @(negedge i_mclk);
        `chk("irq0_other", 1'b1, irq0)
        rd8(ADDR_CH0_CNT_HI, q);
        repeat (3) @(negedge i_mclk);
        `chk("irq0_clear", 1'b0, irq0)
        // channel 1 periodic toggle
        wr8(ADDR_CH1_RLD_LO, 8'h03);
        wr8(ADDR_CH1_RLD_HI, 8'h00);
        wr8(ADDR_CH1_CNT_LO, 8'h03);
        wr8(ADDR_CH1_CNT_HI, 8'h00);
        wr8(ADDR_CTRL, 8'h26);
        wait_pin(t1);
        wait_pin(t2);
        `chk("toggle_period", 4 * TICK_DIV, t2 - t1)
        repeat (3) @(negedge i_mclk);
        `chk("irq1_on", 1'b1, irq1)
        rd8(ADDR_CTRL, q);
        `chk("flag1", 1'b1, q[CTRL_FLAG1_BIT])
        wr8(ADDR_CTRL, 8'h06);
        repeat (3) @(negedge i_mclk);
        `chk("irq1_masked", 1'b0, irq1)
        // every pin action code
        foreach (codes[i]) begin
            wr8(ADDR_CTRL, 8'h00);
            // let a zero event already in flight reach the pin
            repeat (3) @(negedge i_mclk);
            prev = pin;
            wr8(ADDR_CH1_CNT_LO, 8'h02);
            rd8(ADDR_CTRL, q);
            rd8(ADDR_CH1_CNT_LO, q);
            wr8(ADDR_CTRL, {4'h0, codes[i], 2'b10});
            n = 0;
            q = 8'h00;
            while (q[CTRL_FLAG1_BIT] !== 1'b1 && n < 200) begin
                rd8(ADDR_CTRL, q);
                n++;
            end
            `chk("flag1_poll", 1'b1, q[CTRL_FLAG1_BIT])
            repeat (3) @(negedge i_mclk);
            `chk("pin_action", exp_pin(codes[i], prev), pin)
        end
        wr8(ADDR_CTRL, 8'h00);
        // address function when timer output not selected
        pin_sel = 1'b0;
        repeat (8) begin
            addr_bit18 = 1'($urandom);
            @(negedge i_mclk);
            `chk("pin_addr", addr_bit18, pin)
        end
        summarize();
    end
endmodule
